// file: include/bba_pkg.sv
// package for the backplane bus master arbiter
// assumes a 20 MHz system clock and a bus clock no faster than 100 ns
package bba_pkg;
   localparam int SYS_CLK_HZ = 20000000;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int SETUP_NS = 100;
   localparam int SETUP_CYC = ((SETUP_NS * (SYS_CLK_HZ / 1000000)) + 999) / 1000;
   localparam int WDOG_MS = 10;
   localparam int WDOG_CYC = WDOG_MS * (SYS_CLK_HZ / 1000);
   localparam int CNT_W = 20;
   localparam logic [1:0] XMODE_OP = 2'h0;
   localparam logic [1:0] XMODE_INSTR = 2'h2;
   localparam int XMODE_KEEP_BIT = 0;

   typedef enum logic [1:0] {
      BBA_MEM_RD = 2'h0,
      BBA_MEM_WR = 2'h1,
      BBA_IO_RD = 2'h2,
      BBA_IO_WR = 2'h3
   } bba_cmd_type;

   typedef struct packed {
      bba_cmd_type cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic last;
   } bba_req_type;

   typedef struct packed {
      logic mem_rd;
      logic mem_wr;
      logic io_rd;
      logic io_wr;
   } bba_strobe_type;

   typedef enum logic [3:0] {
      BS_IDLE = 4'h1,
      BS_BID = 4'h2,
      BS_WAIT = 4'h4,
      BS_OWN = 4'h8
   } bba_bstate_type;

   typedef enum logic [3:0] {
      XS_IDLE = 4'h1,
      XS_SETUP = 4'h2,
      XS_CMD = 4'h4,
      XS_END = 4'h8
   } bba_xstate_type;
endpackage

// file: src/bba_arbiter.sv
// bus master arbiter and transfer engine for a shared backplane
// assumes bus pins arrive asynchronous; contention logic runs on bus_clk
// Behaviour
// RULE1: priority out combines own request and priority in
// RULE2: requesting drives priority out high
// RULE3: top module priority in tied low
// RULE4: wait priority in low and busy high
// RULE5: then pull busy low and transfer
// RULE6: contention lines change on bus clock fall
// RULE7: bus clock period at least 100 ns
// RULE8: bid one cycle, claim busy next cycle
// RULE9: serial chain at most three masters
// RULE10: serial mode leaves bus request unused
// RULE11: parallel mode external encoder grants priority in
// RULE12: mode 00 releases after every operation
// RULE13: mode 10 releases at instruction boundary
// RULE14: mode bit4 set keeps bus forever; the code keeps it on xchg_mode bit 0
// RULE15: slave asserts transfer ack on completion
// RULE16: advance ack ignored unless jumper fitted
// RULE17: completion always needs transfer ack
// RULE18: only master drives address and command
// RULE19: eight data and sixteen address lines
// RULE20: distinct strobe per command kind
// RULE21: all bus signals are active low
// RULE22: address/data stable 100 ns before strobe
// RULE23: hold strobe until ack, watchdog 10 ms
// RULE24: slave drops ack within 100 ns
// RULE25: release busy only at allowed idle point
// RULE26: synchronise priority in and busy first
`timescale 1ns/1ps
module bba_arbiter #(
   parameter int WDOG_COUNT = bba_pkg::WDOG_CYC
) (
   // system
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic bus_clk_n,
   // configuration
   input wire logic [1:0] xchg_mode,
   input wire logic parallel_mode,
   input wire logic advance_ack_n_jumper,
   // processor side request
   input wire logic req_valid,
   input wire bba_pkg::bba_req_type req,
   output logic req_ready,
   output logic done,
   output logic timeout,
   output logic [bba_pkg::DATA_W-1:0] rdata,
   // contention pins
   input wire logic priority_in_n,
   output logic priority_out_n,
   output logic arbitration_request_n,
   input wire logic busy_in_n,
   output logic busy_out_n,
   output logic busy_oe,
   // transfer pins
   output logic [bba_pkg::ADDR_W-1:0] addr_out_n,
   output logic addr_oe,
   input wire logic [bba_pkg::DATA_W-1:0] data_in_n,
   output logic [bba_pkg::DATA_W-1:0] data_out_n,
   output logic data_oe,
   output logic mem_read_cmd_n,
   output logic mem_write_cmd_n,
   output logic io_read_cmd_n,
   output logic io_write_cmd_n,
   input wire logic transfer_ack_n,
   input wire logic advance_ack_n
);
   // ------------------------------------------------------------
   // bus clock domain: contention (falling edge of bus clock)
   // ------------------------------------------------------------
   logic want_s1_reg, want_s2_reg;
   logic rel_s1_reg, rel_s2_reg;
   logic prn_s1_reg, prn_s2_reg, bsy_s1_reg, bsy_s2_reg;
   bba_pkg::bba_bstate_type bst_reg, bst_next;
   logic pout_reg, pout_next, arbitration_request_n_reg, arbitration_request_n_next, bown_reg, bown_next;
   logic own_tgl_reg, own_tgl_next;
   // system-side request flags, synchronised into the bus clock domain below
   logic want_reg, want_next, rel_reg, rel_next;
   logic ownflag_reg, ownflag_next;

   // the bus clock line is active low, so its falling edge is the posedge of bus_clk_n
   always_ff @(posedge bus_clk_n or negedge arst_n) begin // RULE6
      if (!arst_n) begin
         want_s1_reg <= 1'b0;
         want_s2_reg <= 1'b0;
         rel_s1_reg <= 1'b0;
         rel_s2_reg <= 1'b0;
         prn_s1_reg <= 1'b1;
         prn_s2_reg <= 1'b1;
         bsy_s1_reg <= 1'b0;
         bsy_s2_reg <= 1'b0;
      end else begin
         want_s1_reg <= want_reg;
         want_s2_reg <= want_s1_reg;
         rel_s1_reg <= rel_reg;
         rel_s2_reg <= rel_s1_reg;
         prn_s1_reg <= priority_in_n; // RULE26
         prn_s2_reg <= prn_s1_reg;
         bsy_s1_reg <= busy_in_n;
         bsy_s2_reg <= bsy_s1_reg;
      end
   end

   always_comb begin
      bst_next = bst_reg;
      arbitration_request_n_next = 1'b1;
      bown_next = bown_reg;
      own_tgl_next = own_tgl_reg;
      case (bst_reg)
         bba_pkg::BS_IDLE: begin
            bown_next = 1'b0;
            if (want_s2_reg) begin
               bst_next = bba_pkg::BS_BID;
            end
         end
         bba_pkg::BS_BID: begin
            // one full bus cycle of bid before any claim
            bst_next = bba_pkg::BS_WAIT; // RULE8
         end
         bba_pkg::BS_WAIT: begin
            if (!want_s2_reg) begin
               bst_next = bba_pkg::BS_IDLE;
            end else if (!prn_s2_reg && bsy_s2_reg) begin // RULE4
               bst_next = bba_pkg::BS_OWN;
               bown_next = 1'b1; // RULE5
               own_tgl_next = ~own_tgl_reg;
            end
         end
         bba_pkg::BS_OWN: begin
            // release only on request from the system side, already mode-qualified
            if (rel_s2_reg) begin // RULE25
               bst_next = bba_pkg::BS_IDLE;
               bown_next = 1'b0;
            end
         end
         default: begin
            bst_next = bba_pkg::BS_IDLE;
            bown_next = 1'b0;
         end
      endcase
      // in serial mode the request line stays inactive
      if (parallel_mode && bst_reg != bba_pkg::BS_IDLE) begin // RULE10
         arbitration_request_n_next = 1'b0;
      end
      // high when requesting, else pass the chain's priority through
      pout_next = (bst_reg != bba_pkg::BS_IDLE) | prn_s2_reg; // RULE1 RULE2
   end

   always_ff @(posedge bus_clk_n or negedge arst_n) begin
      if (!arst_n) begin
         bst_reg <= bba_pkg::BS_IDLE;
         pout_reg <= 1'b1;
         arbitration_request_n_reg <= 1'b1;
         bown_reg <= 1'b0;
         own_tgl_reg <= 1'b0;
      end else begin
         bst_reg <= bst_next;
         pout_reg <= pout_next;
         arbitration_request_n_reg <= arbitration_request_n_next;
         bown_reg <= bown_next;
         own_tgl_reg <= own_tgl_next;
      end
   end

   assign priority_out_n = pout_reg;
   assign arbitration_request_n = arbitration_request_n_reg;
   // open-drain style busy: drive low only while owning
   assign busy_out_n = 1'b0; // RULE21
   assign busy_oe = bown_reg;

   // ------------------------------------------------------------
   // system clock domain: synchronisers and transfer engine
   // ------------------------------------------------------------
   logic own_s1_reg, own_s2_reg, own_s3_reg;
   logic transfer_ack_n_s1_reg, transfer_ack_n_s2_reg, advance_ack_n_s1_reg, advance_ack_n_s2_reg;
   bba_pkg::bba_xstate_type xst_reg, xst_next;
   bba_pkg::bba_req_type cur_reg, cur_next;
   bba_pkg::bba_strobe_type stb_reg, stb_next;
   logic [bba_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [bba_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic rdy_reg, rdy_next, done_reg, done_next, to_reg, to_next;
   logic aoe_reg, aoe_next, doe_reg, doe_next, owned, keep_bus;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         own_s1_reg <= 1'b0;
         own_s2_reg <= 1'b0;
         own_s3_reg <= 1'b0;
         transfer_ack_n_s1_reg <= 1'b1;
         transfer_ack_n_s2_reg <= 1'b1;
         advance_ack_n_s1_reg <= 1'b1;
         advance_ack_n_s2_reg <= 1'b1;
      end else begin
         own_s1_reg <= own_tgl_reg;
         own_s2_reg <= own_s1_reg;
         own_s3_reg <= own_s2_reg;
         transfer_ack_n_s1_reg <= transfer_ack_n;
         transfer_ack_n_s2_reg <= transfer_ack_n_s1_reg;
         advance_ack_n_s1_reg <= advance_ack_n;
         advance_ack_n_s2_reg <= advance_ack_n_s1_reg;
      end
   end

   // grant event: edge of the toggle after two flops
   wire grant_evt = own_s2_reg ^ own_s3_reg;
   // advance ack only sampled when the jumper is fitted; still needs transfer ack
   wire ack_seen = !transfer_ack_n_s2_reg; // RULE17
   wire advance_ack_n_seen = advance_ack_n_jumper && !advance_ack_n_s2_reg; // RULE16
   assign keep_bus = xchg_mode[bba_pkg::XMODE_KEEP_BIT]; // RULE14

   always_comb begin
      xst_next = xst_reg;
      cur_next = cur_reg;
      stb_next = stb_reg;
      cnt_next = cnt_reg;
      rdata_next = rdata_reg;
      rdy_next = 1'b0;
      done_next = 1'b0;
      to_next = 1'b0;
      aoe_next = aoe_reg;
      doe_next = doe_reg;
      want_next = want_reg;
      rel_next = rel_reg;
      owned = rel_reg ? 1'b0 : want_reg && ownflag_reg;
      case (xst_reg)
         bba_pkg::XS_IDLE: begin
            if (req_valid && !rdy_reg) begin
               cur_next = req;
               rdy_next = 1'b1;
               want_next = 1'b1;
               rel_next = 1'b0;
               if (owned) begin
                  xst_next = bba_pkg::XS_SETUP;
                  aoe_next = 1'b1; // RULE18
                  doe_next = (req.cmd == bba_pkg::BBA_MEM_WR) || (req.cmd == bba_pkg::BBA_IO_WR);
                  cnt_next = '0;
               end
            end else if (want_reg && !rel_reg && ownflag_reg) begin
               xst_next = bba_pkg::XS_SETUP;
               aoe_next = 1'b1;
               doe_next = (cur_reg.cmd == bba_pkg::BBA_MEM_WR) || (cur_reg.cmd == bba_pkg::BBA_IO_WR);
               cnt_next = '0;
            end
         end
         bba_pkg::XS_SETUP: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == bba_pkg::CNT_W'(bba_pkg::SETUP_CYC - 1)) begin // RULE22
               xst_next = bba_pkg::XS_CMD;
               cnt_next = '0;
               stb_next.mem_rd = cur_reg.cmd == bba_pkg::BBA_MEM_RD; // RULE20
               stb_next.mem_wr = cur_reg.cmd == bba_pkg::BBA_MEM_WR;
               stb_next.io_rd = cur_reg.cmd == bba_pkg::BBA_IO_RD;
               stb_next.io_wr = cur_reg.cmd == bba_pkg::BBA_IO_WR;
            end
         end
         bba_pkg::XS_CMD: begin
            cnt_next = cnt_reg + 1'b1;
            if (ack_seen || (advance_ack_n_seen && ack_seen)) begin // RULE23
               rdata_next = ~data_in_n;
               done_next = 1'b1;
               xst_next = bba_pkg::XS_END;
               stb_next = '0;
            end else if (cnt_reg == bba_pkg::CNT_W'(WDOG_COUNT - 1)) begin // RULE23
               to_next = 1'b1;
               done_next = 1'b1;
               xst_next = bba_pkg::XS_END;
               stb_next = '0;
            end
         end
         bba_pkg::XS_END: begin
            aoe_next = 1'b0;
            doe_next = 1'b0;
            xst_next = bba_pkg::XS_IDLE;
            // hold ownership unless the exchange mode allows letting go here
            if (!keep_bus && (xchg_mode == bba_pkg::XMODE_OP || cur_reg.last)) begin // RULE12 RULE13
               want_next = 1'b0;
               rel_next = 1'b1;
            end
         end
         default: begin
            xst_next = bba_pkg::XS_IDLE;
            stb_next = '0;
         end
      endcase
   end

   // ownership seen on the system side; cleared when we let go
   always_comb begin
      ownflag_next = ownflag_reg;
      if (grant_evt) begin
         ownflag_next = 1'b1;
      end else if (rel_next && !rel_reg) begin
         ownflag_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         xst_reg <= bba_pkg::XS_IDLE;
         cur_reg <= '0;
         stb_reg <= '0;
         cnt_reg <= '0;
         rdata_reg <= '0;
         rdy_reg <= 1'b0;
         done_reg <= 1'b0;
         to_reg <= 1'b0;
         aoe_reg <= 1'b0;
         doe_reg <= 1'b0;
         want_reg <= 1'b0;
         rel_reg <= 1'b0;
         ownflag_reg <= 1'b0;
      end else begin
         xst_reg <= xst_next;
         cur_reg <= cur_next;
         stb_reg <= stb_next;
         cnt_reg <= cnt_next;
         rdata_reg <= rdata_next;
         rdy_reg <= rdy_next;
         done_reg <= done_next;
         to_reg <= to_next;
         aoe_reg <= aoe_next;
         doe_reg <= doe_next;
         want_reg <= want_next;
         rel_reg <= rel_next;
         ownflag_reg <= ownflag_next;
      end
   end

   // bus lines are active low: invert on the way out
   assign addr_out_n = ~cur_reg.addr; // RULE19 RULE21
   assign data_out_n = ~cur_reg.wdata;
   assign addr_oe = aoe_reg;
   assign data_oe = doe_reg;
   assign mem_read_cmd_n = ~stb_reg.mem_rd;
   assign mem_write_cmd_n = ~stb_reg.mem_wr;
   assign io_read_cmd_n = ~stb_reg.io_rd;
   assign io_write_cmd_n = ~stb_reg.io_wr;
   assign req_ready = rdy_reg;
   assign done = done_reg;
   assign timeout = to_reg;
   assign rdata = rdata_reg;
endmodule

// file: test/bba_slave_model.sv
// far-side slave model for the bus master arbiter
// assumes strobes and address arrive inverted, as on the wire
`timescale 1ns/1ps
module bba_slave_model (
   // clock
   input wire logic sys_clk,
   // master side
   input wire bba_pkg::bba_strobe_type cmd_n,
   input wire logic [15:0] addr_n,
   input wire logic [7:0] wdata_n,
   // answer delay, zero never answers
   input wire logic [7:0] ack_wait,
   // slave answers
   output logic [7:0] data_n,
   output logic ack_n,
   output bba_pkg::bba_strobe_type seen_cmd,
   output logic [15:0] seen_addr,
   output logic [7:0] seen_data
);
   logic [7:0] cnt;
   initial begin
      ack_n = 1'b1;
      cnt = 8'h0;
   end
   // address is only ever read here, never driven
   always @(posedge sys_clk) begin
      if (&cmd_n) begin
         ack_n <= 1'b1;
         cnt <= 8'h0;
      end else begin
         cnt <= cnt + 8'h1;
         if (ack_wait != 8'h0 && cnt == ack_wait) begin
            ack_n <= 1'b0;
            seen_cmd <= ~cmd_n;
            seen_addr <= ~addr_n;
            seen_data <= ~wdata_n;
         end
      end
   end
   // read data only under a read strobe, else the pull-up level
   assign data_n = (!cmd_n.mem_rd || !cmd_n.io_rd) ? (addr_n[7:0] ^ 8'h5a) : 8'hff;
endmodule

// file: test/bba_arbiter_asserts.sv
// port checker for the bus master arbiter
// bound to every bba_arbiter instance
`timescale 1ns/1ps
module bba_arbiter_asserts #(
   parameter int WDOG_COUNT = 50
) (
   // clocks
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic bus_clk_n,
   // setup and request
   input wire logic [1:0] xchg_mode,
   input wire logic parallel_mode,
   input wire bba_pkg::bba_req_type req,
   input wire logic req_ready,
   input wire logic done,
   input wire logic timeout,
   // contention
   input wire logic priority_in_n,
   input wire logic priority_out_n,
   input wire logic arbitration_request_n,
   input wire logic busy_in_n,
   input wire logic busy_oe,
   // transfer
   input wire logic addr_oe,
   input wire logic mem_read_cmd_n,
   input wire logic mem_write_cmd_n,
   input wire logic io_read_cmd_n,
   input wire logic io_write_cmd_n,
   input wire logic transfer_ack_n
);
   logic cmd_on;
   logic last_reg;
   logic [19:0] cnt_reg;
   assign cmd_on = !(mem_read_cmd_n && mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n);
   // strobe run length, and the instruction-end flag of the op taken
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         last_reg <= 1'b0;
         cnt_reg <= 20'h0;
      end else begin
         if (req_ready) begin
            last_reg <= req.last;
         end
         cnt_reg <= cmd_on ? cnt_reg + 20'h1 : 20'h0;
      end
   end
   sequence strobe_end_s;
      cmd_on ##1 !cmd_on;
   endsequence
   strobe_onehot_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $onehot0(~{mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n})) else $error("two strobes");
   strobe_owner_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cmd_on |-> busy_oe && addr_oe) else $error("strobe without ownership");
   addr_setup_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(cmd_on) |-> $past(addr_oe, 2)) else $error("address setup short");
   strobe_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      strobe_end_s |-> !$past(transfer_ack_n) || $past(cnt_reg) >= WDOG_COUNT - 2) else $error("strobe dropped early");
   wdog_bound_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cnt_reg <= WDOG_COUNT + 2) else $error("watchdog late");
   done_ack_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      done && !timeout |-> !$past(transfer_ack_n, 2)) else $error("done without ack");
   keep_mode_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      xchg_mode[0] && busy_oe |=> busy_oe) else $error("bus released in keep mode");
   instr_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      xchg_mode == bba_pkg::XMODE_INSTR && done && !last_reg |=> busy_oe [*4]) else $error("released mid instruction");
   op_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      xchg_mode == bba_pkg::XMODE_OP && done |-> ##[0:10] !busy_oe) else $error("no release after op");
   serial_noreq_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !parallel_mode |-> arbitration_request_n) else $error("request line used in serial mode");
   no_grant_a: assert property (@(posedge bus_clk_n) disable iff (!arst_n)
      ((priority_in_n || !busy_in_n) && !busy_oe) [*4] |=> !busy_oe) else $error("claim without grant");
   bid_first_a: assert property (@(posedge bus_clk_n) disable iff (!arst_n)
      $rose(busy_oe) |-> $past(priority_out_n)) else $error("claim without bid");
   chain_ripple_a: assert property (@(posedge bus_clk_n) disable iff (!arst_n)
      priority_in_n [*4] |-> priority_out_n) else $error("priority not passed on");
endmodule
bind bba_arbiter bba_arbiter_asserts #(.WDOG_COUNT(WDOG_COUNT)) bba_arbiter_asserts_i (.*);

// file: test/tb_backplane_bus_master_arbiter.sv
// self-checking bench for the bus master arbiter
// drives the processor side, the other masters and a slave model
`timescale 1ns/1ps
module tb_backplane_bus_master_arbiter;
   logic sys_clk = 1'b0;
   logic bus_clk_n = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] xchg_mode = 2'h0;
   logic parallel_mode = 1'b0;
   logic advance_ack_n_jumper = 1'b0;
   logic advance_ack_n = 1'b1;
   logic req_valid = 1'b0;
   bba_pkg::bba_req_type req = '0;
   // one higher master ahead of us: a chain of two, inside the limit of three
   logic priority_in_n = 1'b0;
   logic other_busy_n = 1'b1;
   logic [7:0] ack_wait = 8'h3;
   logic req_ready, done, timeout, priority_out_n, arbitration_request_n, to;
   logic busy_out_n, busy_oe, addr_oe, data_oe, transfer_ack_n;
   logic mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n;
   logic [7:0] rdata, data_out_n, sl_rd_n, sl_data, rd;
   logic [15:0] addr_out_n, sl_addr;
   bba_pkg::bba_strobe_type sl_cmd;
   wire busy_in_n = busy_oe ? busy_out_n : other_busy_n;
   int fail_count = 0;
   int n_tests = 0;
   always #25 sys_clk = ~sys_clk;
   initial begin
      #7;
      forever #62.5 bus_clk_n = ~bus_clk_n;
   end
   bba_arbiter #(.WDOG_COUNT(50)) bba_arbiter_i (.sys_clk, .arst_n, .bus_clk_n, .xchg_mode, .parallel_mode,
      .advance_ack_n_jumper, .req_valid, .req, .req_ready, .done, .timeout, .rdata, .priority_in_n, .priority_out_n,
      .arbitration_request_n, .busy_in_n, .busy_out_n, .busy_oe, .addr_out_n, .addr_oe,
      .data_in_n(data_oe ? data_out_n : sl_rd_n), .data_out_n, .data_oe, .mem_read_cmd_n, .mem_write_cmd_n,
      .io_read_cmd_n, .io_write_cmd_n, .transfer_ack_n, .advance_ack_n);
   bba_slave_model bba_slave_model_i (.sys_clk, .addr_n(addr_out_n), .wdata_n(data_out_n), .ack_wait,
      .cmd_n({mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n}), .data_n(sl_rd_n),
      .ack_n(transfer_ack_n), .seen_cmd(sl_cmd), .seen_addr(sl_addr), .seen_data(sl_data));
   // ----
   // shared tasks
   // ----
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
   endtask
   // request is taken at once while idle, so wait for it here
   task automatic issue(input bba_pkg::bba_cmd_type c, input logic [15:0] a, input logic [7:0] d, input logic l);
      int i;
      i = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= '{c, a, d, l};
      while (req_ready !== 1'b1 && i < 50) begin
         @(posedge sys_clk);
         i++;
      end
      req_valid <= 1'b0;
   endtask
   task automatic finish_op;
      int i;
      i = 0;
      while (done !== 1'b1 && i < 900) begin
         @(posedge sys_clk);
         i++;
      end
      rd = rdata;
      to = timeout;
      chk("done", 16'h1, done);
   endtask
   task automatic op(input bba_pkg::bba_cmd_type c, input logic [15:0] a, input logic [7:0] d, input logic l);
      issue(c, a, d, l);
      finish_op();
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_cmds;
      for (int k = 0; k < 4; k++) begin
         op(bba_pkg::bba_cmd_type'(k), 16'ha5c0 + 16'(k), 8'h30 + 8'(k), 1'b1);
         chk("strobe", 16'h8 >> k, sl_cmd);
         chk("address", 16'ha5c0 + 16'(k), sl_addr);
         if (k % 2 == 1) chk("wdata", 8'h30 + 8'(k), sl_data);
         else chk("rdata", (8'hc0 + 8'(k)) ^ 8'h5a, rd);
         repeat (12) @(posedge sys_clk);
         chk("released", 16'h0, busy_oe);
      end
      $display("test commands done");
   endtask
   task automatic t_instr;
      xchg_mode <= 2'h2;
      op(bba_pkg::BBA_MEM_RD, 16'h1234, 8'h0, 1'b0);
      repeat (12) @(posedge sys_clk);
      chk("held in instruction", 16'h1, busy_oe);
      op(bba_pkg::BBA_MEM_WR, 16'h1235, 8'h77, 1'b1);
      repeat (12) @(posedge sys_clk);
      chk("released at boundary", 16'h0, busy_oe);
      $display("test instruction mode done");
   endtask
   task automatic t_keep;
      xchg_mode <= 2'h1;
      op(bba_pkg::BBA_IO_WR, 16'h0042, 8'h99, 1'b1);
      repeat (20) @(posedge sys_clk);
      chk("kept", 16'h1, busy_oe);
      xchg_mode <= 2'h0;
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("reset strobes", 16'hf, {mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n});
      chk("reset busy", 16'h0, busy_oe);
      do_reset();
      $display("test keep mode done");
   endtask
   task automatic t_arb;
      priority_in_n <= 1'b1;
      other_busy_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk("ripple", 16'h1, priority_out_n);
      issue(bba_pkg::BBA_IO_RD, 16'h00a7, 8'h0, 1'b1);
      repeat (30) @(posedge sys_clk);
      chk("higher request wins", 16'h0, busy_oe);
      chk("bid", 16'h1, priority_out_n);
      priority_in_n <= 1'b0;
      repeat (30) @(posedge sys_clk);
      chk("bus still busy", 16'h0, busy_oe);
      other_busy_n <= 1'b1;
      finish_op();
      chk("granted read", 16'h00fd, rd);
      $display("test arbitration done");
   endtask
   task automatic t_wdog;
      ack_wait <= 8'h0;
      advance_ack_n <= 1'b0;
      for (int j = 0; j < 2; j++) begin
         advance_ack_n_jumper <= j[0];
         op(bba_pkg::BBA_MEM_RD, 16'h0800, 8'h0, 1'b1);
         chk("watchdog end", 16'h1, to);
         repeat (12) @(posedge sys_clk);
      end
      ack_wait <= 8'h3;
      advance_ack_n <= 1'b1;
      advance_ack_n_jumper <= 1'b0;
      $display("test watchdog done");
   endtask
   task automatic t_par;
      parallel_mode <= 1'b1;
      priority_in_n <= 1'b1;
      issue(bba_pkg::BBA_MEM_WR, 16'h2000, 8'h5c, 1'b1);
      repeat (12) @(posedge sys_clk);
      chk("parallel request", 16'h0, arbitration_request_n);
      chk("waits for encoder", 16'h0, busy_oe);
      priority_in_n <= 1'b0;
      finish_op();
      chk("parallel write", 16'h5c, sl_data);
      repeat (12) @(posedge sys_clk);
      parallel_mode <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("serial request unused", 16'h1, arbitration_request_n);
      $display("test parallel done");
   endtask
   initial begin
      do_reset();
      repeat (10) @(posedge sys_clk);
      chk("idle chain", 16'h0, priority_out_n);
      t_cmds();
      t_instr();
      t_keep();
      t_arb();
      t_wdog();
      t_par();
      complete_run();
   end
   initial begin
      #300000;
      fail_count++;
      complete_run();
   end
endmodule
